// File: bench/sop_properties.sv
// concurrent checks on the object link between master end and device end
`timescale 1ns/10ps
`default_nettype none
module sop_properties #(
    parameter int NUM_CH = 4
) (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        reqValid,
    input wire logic        reqWrite,
    input wire logic [15:0] reqIndex,
    input wire logic [7:0]  reqSub,
    input wire logic [31:0] reqData,
    input wire logic        rspValid,
    input wire logic [31:0] rspData,
    input wire logic        rspAbort
);
    import sop_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // request decode on the output sync object
    wire rdSync = reqValid && !reqWrite && reqIndex == IDX_OUT_SYNC;
    wire wrSync = reqValid && reqWrite && reqIndex == IDX_OUT_SYNC;

    rsp_latency_a: assert property (reqValid |=> rspValid)
        else $error("answer not one cycle after request");
    rsp_cause_a: assert property (rspValid |-> $past(reqValid))
        else $error("answer without a request");
    rsp_pulse_a: assert property (rspValid |=> !rspValid)
        else $error("answer stood longer than one cycle");
    write_zero_a: assert property (rspValid && $past(reqWrite) |-> rspData == 32'h0)
        else $error("write answer carried data");
    top_sub_a: assert property (rdSync && reqSub == SUB_COUNT |=> !rspAbort && rspData == 32'(OUT_SYNC_MAX_SUB))
        else $error("highest subindex read wrong");
    modes_word_a: assert property (rdSync && reqSub == SUB_SUPPORTED |=> rspData == 32'(MODES_SUPPORTED))
        else $error("supported modes word wrong");
    mode_refuse_a: assert property (wrSync && reqSub == SUB_MODE && reqData > 32'h3 |=> rspAbort)
        else $error("bad mode code accepted");
    cmd_refuse_a: assert property (wrSync && reqSub == SUB_COMMAND && reqData > 32'h1 |=> rspAbort)
        else $error("bad command accepted");
    ro_refuse_a: assert property (wrSync && (reqSub == SUB_SUPPORTED || reqSub == SUB_COUNT) |=> rspAbort)
        else $error("read-only entry accepted a write");
    count_limit_a: assert property (reqValid && reqWrite && reqIndex == IDX_OUT_ASSIGN && reqSub == SUB_COUNT
        && reqData > 32'(NUM_CH) |=> rspAbort)
        else $error("list count above channels accepted");

    // main traffic kinds seen on the link
    cover property (wrSync ##1 rspValid && !rspAbort);
    cover property (rspValid && rspAbort);
    cover property (rdSync && reqSub == SUB_MISSED);
endmodule
`default_nettype wire

// File: bench/sync_output_parameter_objects_test.sv
// self-checking bench: master end drives the device end over the object link
`timescale 1ns/10ps
`default_nettype none
module sync_output_parameter_objects_test;
    import sop_pkg::*;
    localparam logic [31:0] MIN_CYC = 32'h0000_03e8;
    localparam logic [31:0] MIN_GAP = 32'h0000_0190;
    localparam logic [7:0]  DSUB [13] = '{SUB_COUNT, SUB_SUPPORTED, SUB_MODE, SUB_CYCLE, SUB_SHIFT, SUB_MIN_CYCLE,
        SUB_CALC_COPY, SUB_COMMAND, SUB_DELAY, SUB_MISSED, SUB_OVERRUN, SUB_SHORT, SUB_SYNC_FAIL};
    localparam logic [31:0] DVAL [13] = '{32'h20, 32'h8007, 32'h0, 32'h0, 32'h0, MIN_CYC, MIN_GAP, 32'h0, 32'h0,
        32'h0, 32'h0, 32'h0, 32'h0};
    typedef struct packed {logic [31:0] d; logic a;} sop_note_s;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic        firstPulseIn = 1'b0;
    logic        secondPulseIn = 1'b0;
    logic        smEventIn = 1'b0;
    logic        runStateIn = 1'b0;
    logic        calcBusy = 1'b0;
    logic        cmdValid = 1'b0;
    logic        cmdWrite = 1'b0;
    logic [15:0] cmdIndex = 16'h0;
    logic [7:0]  cmdSub = 8'h0;
    logic [31:0] cmdData = 32'h0;
    logic        cycleStart, outputApply, measuring, cmdReady, doneValid, doneAbort;
    logic [31:0] doneData;
    logic [31:0] seed = 32'h0001_56a1;
    int          failures = 0;
    int          checked = 0;
    int          starts = 0;
    int          applies = 0;
    sop_note_s   notes[$];
    sop_note_s   note;

    // 25 MHz reference
    always #20 ref_clk = ~ref_clk;

    sop_od_if od();
    sop_device #(.NUM_CH(4), .MIN_CYCLE_NS(MIN_CYC), .MIN_GAP_NS(MIN_GAP)) u_sop_device (.ref_clk(ref_clk),
        .rst(rst), .od(od), .firstPulseIn(firstPulseIn), .secondPulseIn(secondPulseIn), .smEventIn(smEventIn),
        .runStateIn(runStateIn), .calcBusy(calcBusy), .cycleStart(cycleStart), .outputApply(outputApply),
        .measuring(measuring));
    sop_master u_sop_master (.ref_clk(ref_clk), .rst(rst), .od(od), .cmdValid(cmdValid), .cmdWrite(cmdWrite),
        .cmdIndex(cmdIndex), .cmdSub(cmdSub), .cmdData(cmdData), .cmdReady(cmdReady), .doneValid(doneValid),
        .doneData(doneData), .doneAbort(doneAbort));
    sop_properties #(.NUM_CH(4)) u_props (.ref_clk(ref_clk), .rst(rst), .reqValid(od.reqValid),
        .reqWrite(od.reqWrite), .reqIndex(od.reqIndex), .reqSub(od.reqSub), .reqData(od.reqData),
        .rspValid(od.rspValid), .rspData(od.rspData), .rspAbort(od.rspAbort));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // one access: wait for ready, note the expected answer, drive the request for one cycle, then wait for the answer
    task automatic acc(input logic w, input logic [15:0] i, input logic [7:0] s, input logic [31:0] d,
                       input logic [31:0] ed, input logic ea);
        int n;
        n = 0;
        while (cmdReady !== 1'b1 && n < 20) begin
            @(negedge ref_clk);
            n++;
        end
        notes.push_back({ed, ea});
        @(posedge ref_clk);
        cmdValid <= 1'b1;
        cmdWrite <= w;
        cmdIndex <= i;
        cmdSub <= s;
        cmdData <= d;
        @(posedge ref_clk);
        cmdValid <= 1'b0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (doneValid !== 1'b1 && n < 40);
        if (doneValid !== 1'b1) begin
            failures++;
            finish_test();
        end
    endtask

    task automatic rd(input logic [15:0] i, input logic [7:0] s, input logic [31:0] e);
        acc(1'b0, i, s, 32'h0, e, 1'b0);
    endtask

    task automatic wr(input logic [15:0] i, input logic [7:0] s, input logic [31:0] d, input logic ea);
        acc(1'b1, i, s, d, 32'h0, ea);
    endtask

    // pin pulse of two cycles; mask order is event, pulse two, pulse one
    task automatic pulse(input logic [2:0] m);
        @(posedge ref_clk);
        {smEventIn, secondPulseIn, firstPulseIn} <= m;
        repeat (2) @(posedge ref_clk);
        {smEventIn, secondPulseIn, firstPulseIn} <= 3'h0;
        repeat (6) @(posedge ref_clk);
    endtask

    // answer watcher: oldest note against each completion; pulses counted
    always @(negedge ref_clk) begin
        if (cycleStart === 1'b1) starts++;
        if (outputApply === 1'b1) applies++;
        if (doneValid === 1'b1) begin
            note = notes.pop_front();
            check(doneData, note.d);
            check({31'h0, doneAbort}, {31'h0, note.a});
        end
    end

    initial begin
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        runStateIn <= 1'b1;
        repeat (5) @(posedge ref_clk);
        for (int k = 1; k <= 4; k++) begin
            rd(IDX_OUT_ASSIGN, 8'(k), {16'h0, OUT_MAP_BASE + 16'(k - 1)});
            rd(IDX_IN_ASSIGN, 8'(k), {16'h0, IN_MAP_BASE + 16'(k - 1)});
        end
        rd(IDX_OUT_ASSIGN, SUB_COUNT, 32'h4);
        rd(IDX_IN_ASSIGN, SUB_COUNT, 32'h4);
        for (int k = 0; k < 13; k++) rd(IDX_OUT_SYNC, DSUB[k], DVAL[k]);
        // refused writes leave entries alone
        wr(IDX_OUT_SYNC, SUB_MODE, 32'h4, 1'b1);
        wr(IDX_OUT_SYNC, SUB_COMMAND, 32'h2, 1'b1);
        wr(IDX_OUT_SYNC, SUB_SUPPORTED, 32'h0, 1'b1);
        wr(IDX_OUT_SYNC, SUB_COUNT, 32'h0, 1'b1);
        wr(IDX_OUT_SYNC, 8'h07, 32'h0, 1'b1);
        wr(IDX_OUT_ASSIGN, SUB_COUNT, 32'h5, 1'b1);
        rd(IDX_OUT_SYNC, SUB_MODE, 32'h0);
        wr(IDX_OUT_ASSIGN, SUB_COUNT, 32'h2, 1'b0);
        rd(IDX_OUT_ASSIGN, SUB_COUNT, 32'h2);
        for (int k = 1; k <= 4; k++) begin
            seed = lfsr(seed);
            wr(IDX_OUT_ASSIGN, 8'(k), {16'h0, seed[15:0]}, 1'b0);
            wr(IDX_IN_ASSIGN, 8'(k), {16'h0, seed[31:16]}, 1'b0);
            rd(IDX_OUT_ASSIGN, 8'(k), {16'h0, seed[15:0]});
            rd(IDX_IN_ASSIGN, 8'(k), {16'h0, seed[31:16]});
        end
        for (int m = 0; m < 4; m++) begin
            wr(IDX_OUT_SYNC, SUB_MODE, 32'(m), 1'b0);
            rd(IDX_OUT_SYNC, SUB_MODE, 32'(m));
        end
        // pulse-one mode, short shift: one missed event, one short gap
        wr(IDX_OUT_SYNC, SUB_MODE, 32'h2, 1'b0);
        wr(IDX_OUT_SYNC, SUB_SHIFT, 32'h50, 1'b0);
        pulse(3'h4);
        pulse(3'h1);
        pulse(3'h4);
        pulse(3'h1);
        pulse(3'h1);
        pulse(3'h2);
        rd(IDX_OUT_SYNC, SUB_MISSED, 32'h1);
        rd(IDX_OUT_SYNC, SUB_SHORT, 32'h1);
        rd(IDX_OUT_SYNC, SUB_SYNC_FAIL, 32'h0);
        check(32'(applies), 32'h3);
        // long shift: the next pulse one lands while apply is still pending
        wr(IDX_OUT_SYNC, SUB_SHIFT, 32'h0fa0, 1'b0);
        pulse(3'h4);
        pulse(3'h1);
        pulse(3'h1);
        repeat (110) @(posedge ref_clk);
        rd(IDX_OUT_SYNC, SUB_MISSED, 32'h2);
        rd(IDX_OUT_SYNC, SUB_OVERRUN, 32'h1);
        rd(IDX_OUT_SYNC, SUB_SYNC_FAIL, 32'h1);
        check(32'(starts), 32'h5);
        // event mode trigger while local processing is busy
        wr(IDX_OUT_SYNC, SUB_MODE, 32'h1, 1'b0);
        @(posedge ref_clk);
        calcBusy <= 1'b1;
        pulse(3'h4);
        calcBusy <= 1'b0;
        rd(IDX_OUT_SYNC, SUB_OVERRUN, 32'h2);
        // leaving and re-entering run state clears the counters
        @(posedge ref_clk);
        runStateIn <= 1'b0;
        repeat (5) @(posedge ref_clk);
        runStateIn <= 1'b1;
        repeat (5) @(posedge ref_clk);
        for (int k = 9; k < 12; k++) rd(IDX_OUT_SYNC, DSUB[k], 32'h0);
        // measurement start clears the measured entries
        wr(IDX_OUT_SYNC, SUB_SHIFT, 32'h50, 1'b0);
        wr(IDX_OUT_SYNC, SUB_COMMAND, 32'h1, 1'b0);
        check({31'h0, measuring}, 32'h1);
        rd(IDX_OUT_SYNC, SUB_SHIFT, 32'h0);
        rd(IDX_OUT_SYNC, SUB_MIN_CYCLE, 32'h0);
        rd(IDX_OUT_SYNC, SUB_COMMAND, 32'h1);
        wr(IDX_OUT_SYNC, SUB_COMMAND, 32'h0, 1'b0);
        check({31'h0, measuring}, 32'h0);
        // free run: a 400 ns local timer gives one start every ten cycles
        wr(IDX_OUT_SYNC, SUB_CYCLE, 32'h190, 1'b0);
        wr(IDX_OUT_SYNC, SUB_MODE, 32'h0, 1'b0);
        @(posedge ref_clk);
        starts = 0;
        repeat (100) @(posedge ref_clk);
        check(32'(starts), 32'ha);
        check(32'(notes.size()), 32'h0);
        finish_test();
    end
endmodule
`default_nettype wire

// File: rtl/sop_device.sv
// device end: assignment lists, output sync parameters, timing and error counters
// Notes on behaviour
// - sync mode: free, event, pulse one, two
// - cycle time meaning follows selected mode
// - pulse-one mode applies outputs after shift
// - supported-modes word read-only, fixed value
// - bits 5:4 report second-pulse shift; the supported word 0x8007 leaves them at zero
// - command 1 starts, 0 stops measurement
// - measuring loads maxima, cleared per start
// - smallest supported cycle time reported
// - required pulse spacing reported read-only
// - second pulse to apply interval reported
// - missed events counted in run state
// - overrun cycles counted in run state
// - short pulse spacing occasions counted
// - late-apply flag set per cycle
// - output list entries default from 0x1600
// - input list entries default from 0x1a00
// - highest subindex reads fixed 0x20
`timescale 1ns/10ps
`default_nettype none
module sop_device #(
    parameter int          NUM_CH       = sop_pkg::DEF_CHANNELS,
    parameter logic [31:0] MIN_CYCLE_NS = 32'h0000_0000,
    parameter logic [31:0] MIN_GAP_NS   = 32'h0000_0000
) (
    input  wire logic ref_clk,
    input  wire logic rst,
    sop_od_if.dev     od,
    input  wire logic firstPulseIn,
    input  wire logic secondPulseIn,
    input  wire logic smEventIn,
    input  wire logic runStateIn,
    input  wire logic calcBusy,
    output logic      cycleStart,
    output logic      outputApply,
    output logic      measuring
);
    import sop_pkg::*;

    localparam int SYNC_N = 4;
    localparam logic [7:0] CH_COUNT = 8'(NUM_CH);

    // two-stage synchronisers for pins, third stage only for edges
    logic [SYNC_N-1:0] syncA;
    logic [SYNC_N-1:0] syncB;
    logic [SYNC_N-1:0] syncC;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            syncA <= '0;
            syncB <= '0;
            syncC <= '0;
        end else begin
            syncA <= {runStateIn, smEventIn, secondPulseIn, firstPulseIn};
            syncB <= syncA;
            syncC <= syncB;
        end
    end
    wire logic [SYNC_N-1:0] rise   = syncB & ~syncC;
    wire logic              p1Rise = rise[0];
    wire logic              p2Rise = rise[1];
    wire logic              smRise = rise[2];
    wire logic              runNow = syncB[3];
    wire logic              runEntry = rise[3];

    // object store
    sop_mode_e   syncMode;
    logic [31:0] cycleTime;
    logic [31:0] shiftTime;
    logic [15:0] command;
    logic [31:0] minCycle;
    logic [31:0] calcCopy;
    logic [31:0] delayTime;
    logic        syncFail;
    logic [7:0]  outCount;
    logic [7:0]  inCount;
    logic [15:0] outList [NUM_CH];
    logic [15:0] inList  [NUM_CH];
    logic [15:0] cntVal  [3];

    function automatic logic hit(input logic [15:0] idx, input logic [7:0] sub, input logic [15:0] wi,
                                 input logic [7:0] ws);
        hit = (idx == wi) && (sub == ws);
    endfunction

    // request decode
    wire logic       wrReq    = od.reqValid && od.reqWrite;
    wire logic [7:0] subM1    = od.reqSub - 8'h01;
    wire logic       listSub  = (od.reqSub != SUB_COUNT) && (od.reqSub <= CH_COUNT);
    wire logic       isOutLst = (od.reqIndex == IDX_OUT_ASSIGN);
    wire logic       isInLst  = (od.reqIndex == IDX_IN_ASSIGN);
    wire logic       isSync   = (od.reqIndex == IDX_OUT_SYNC);
    wire logic       wrMode   = wrReq && hit(od.reqIndex, od.reqSub, IDX_OUT_SYNC, SUB_MODE)
                                && (od.reqData[15:0] <= 16'(SOP_PULSE2));
    wire logic       wrCycle  = wrReq && hit(od.reqIndex, od.reqSub, IDX_OUT_SYNC, SUB_CYCLE);
    wire logic       wrShift  = wrReq && hit(od.reqIndex, od.reqSub, IDX_OUT_SYNC, SUB_SHIFT);
    wire logic       wrCmd    = wrReq && hit(od.reqIndex, od.reqSub, IDX_OUT_SYNC, SUB_COMMAND)
                                && (od.reqData[15:0] <= CMD_START);
    wire logic       wrOutCnt = wrReq && isOutLst && (od.reqSub == SUB_COUNT) && (od.reqData[7:0] <= CH_COUNT);
    wire logic       wrInCnt  = wrReq && isInLst && (od.reqSub == SUB_COUNT) && (od.reqData[7:0] <= CH_COUNT);
    wire logic       wrOutEnt = wrReq && isOutLst && listSub;
    wire logic       wrInEnt  = wrReq && isInLst && listSub;
    wire logic       startMeas = wrCmd && (od.reqData[15:0] == CMD_START) && !measuring;
    wire logic       pulseMode = (syncMode == SOP_PULSE1) || (syncMode == SOP_PULSE2);

    // read mux; unknown entries and refused writes answer with abort
    logic [31:0] rdData;
    logic        rdOk;
    logic        wrOk;
    always_comb begin
        rdData = '0;
        rdOk   = 1'b1;
        wrOk   = 1'b0;
        if ((isOutLst || isInLst) && od.reqSub == SUB_COUNT) begin
            rdData = {24'h000000, isOutLst ? outCount : inCount};
            wrOk   = wrOutCnt || wrInCnt;
        end else if ((isOutLst || isInLst) && listSub) begin
            rdData = {16'h0000, isOutLst ? outList[subM1[1:0]] : inList[subM1[1:0]]};
            wrOk   = 1'b1;
        end else if (isSync) begin
            case (od.reqSub)
                SUB_COUNT:     rdData = {24'h000000, OUT_SYNC_MAX_SUB};
                SUB_MODE:      begin rdData = {16'h0000, syncMode}; wrOk = wrMode; end
                SUB_CYCLE:     begin rdData = cycleTime; wrOk = 1'b1; end
                SUB_SHIFT:     begin rdData = shiftTime; wrOk = 1'b1; end
                SUB_SUPPORTED: rdData = {16'h0000, MODES_SUPPORTED};
                SUB_MIN_CYCLE: rdData = minCycle;
                SUB_CALC_COPY: rdData = calcCopy;
                SUB_COMMAND:   begin rdData = {16'h0000, command}; wrOk = wrCmd; end
                SUB_DELAY:     rdData = delayTime;
                SUB_MISSED:    rdData = {16'h0000, cntVal[0]};
                SUB_OVERRUN:   rdData = {16'h0000, cntVal[1]};
                SUB_SHORT:     rdData = {16'h0000, cntVal[2]};
                SUB_SYNC_FAIL: rdData = {31'h00000000, syncFail};
                default:       rdOk = 1'b0;
            endcase
        end else begin
            rdOk = 1'b0;
        end
    end

    // one-cycle registered answer to every request
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            od.rspValid <= 1'b0;
            od.rspData  <= '0;
            od.rspAbort <= 1'b0;
        end else begin
            od.rspValid <= od.reqValid;
            od.rspData  <= od.reqWrite ? '0 : rdData;
            od.rspAbort <= od.reqValid && (od.reqWrite ? !wrOk : !rdOk);
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++) begin : gList
            always_ff @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    outList[ch] <= OUT_MAP_BASE + 16'(ch);
                    inList[ch]  <= IN_MAP_BASE + 16'(ch);
                end else begin
                    if (wrOutEnt && subM1 == 8'(ch)) outList[ch] <= od.reqData[15:0];
                    if (wrInEnt && subM1 == 8'(ch))  inList[ch]  <= od.reqData[15:0];
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            syncMode  <= SOP_FREE_RUN;
            cycleTime <= TIME_RESET;
            command   <= CMD_STOP;
            outCount  <= CH_COUNT;
            inCount   <= CH_COUNT;
        end else begin
            if (wrMode)   syncMode  <= sop_mode_e'(od.reqData[15:0]);
            if (wrCycle)  cycleTime <= od.reqData;
            if (wrCmd)    command   <= od.reqData[15:0];
            if (wrOutCnt) outCount  <= od.reqData[7:0];
            if (wrInCnt)  inCount   <= od.reqData[7:0];
        end
    end
    assign measuring = (command == CMD_START);

    // elapsed-time counters in ns: local timer, since pulse one, since pulse two, busy time
    logic [31:0] localNs;
    logic [31:0] sinceP1;
    logic [31:0] sinceP2;
    logic [31:0] busyNs;
    logic        applyPending;
    // local timer period in free run; event or pulse otherwise
    wire logic   freeTick = (syncMode == SOP_FREE_RUN) && (cycleTime != TIME_RESET)
                            && (localNs + CLK_STEP_NS >= cycleTime);
    wire logic   trigger  = freeTick || ((syncMode == SOP_SM_EVENT) && smRise)
                            || ((syncMode == SOP_PULSE1) && p1Rise) || ((syncMode == SOP_PULSE2) && p2Rise);
    // shift counted from pulse one; second-pulse mode applies one cycle after its edge
    wire logic   applyDue = applyPending && (((syncMode == SOP_PULSE1) && sinceP1 >= shiftTime)
                            || (syncMode != SOP_PULSE1));
    assign cycleStart  = trigger;
    assign outputApply = applyDue;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            localNs      <= TIME_RESET;
            sinceP1      <= TIME_RESET;
            sinceP2      <= TIME_RESET;
            busyNs       <= TIME_RESET;
            applyPending <= 1'b0;
        end else begin
            localNs      <= freeTick ? TIME_RESET : localNs + CLK_STEP_NS;
            sinceP1      <= p1Rise ? TIME_RESET : sinceP1 + CLK_STEP_NS;
            sinceP2      <= p2Rise ? TIME_RESET : sinceP2 + CLK_STEP_NS;
            busyNs       <= calcBusy ? busyNs + CLK_STEP_NS : TIME_RESET;
            applyPending <= trigger || (applyPending && !applyDue);
        end
    end

    // maxima while measuring, cleared at each start
    wire logic busyEnd = !calcBusy && (busyNs != TIME_RESET);
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            minCycle  <= MIN_CYCLE_NS;
            calcCopy  <= MIN_GAP_NS;
            delayTime <= TIME_RESET;
            shiftTime <= TIME_RESET;
        end else if (startMeas) begin
            minCycle  <= TIME_RESET;
            calcCopy  <= TIME_RESET;
            delayTime <= TIME_RESET;
            shiftTime <= TIME_RESET;
        end else begin
            if (wrShift) shiftTime <= od.reqData;
            if (measuring && busyEnd && busyNs > minCycle) minCycle <= busyNs;
            if (measuring && p2Rise && sinceP1 > calcCopy) calcCopy <= sinceP1;
            if (measuring && applyDue && pulseMode && sinceP2 > delayTime) delayTime <= sinceP2;
            if (measuring && applyDue && pulseMode && sinceP1 > shiftTime && !wrShift) shiftTime <= sinceP1;
        end
    end

    // late apply: pulse one arrives with outputs still pending
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            syncFail <= 1'b0;
        end else if (pulseMode && p1Rise) begin
            syncFail <= applyPending && !applyDue;
        end
    end

    // event tracking for missed events: was an event seen since last pulse one
    logic smSeen;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            smSeen <= 1'b1;
        end else if (p1Rise) begin
            smSeen <= smRise;
        end else if (smRise) begin
            smSeen <= 1'b1;
        end
    end

    wire logic [2:0] cntInc;
    assign cntInc[0] = runNow && pulseMode && p1Rise && !smSeen;
    assign cntInc[1] = runNow && trigger && (calcBusy || applyPending);
    assign cntInc[2] = pulseMode && p2Rise && (sinceP1 < MIN_GAP_NS);

    // hold at top, clear on entering run state
    generate
        for (ch = 0; ch < 3; ch++) begin : gCnt
            sop_sat_counter #(.WIDTH(16)) uCnt (
                .ref_clk (ref_clk),
                .rst     (rst),
                .clear   (runEntry),
                .inc     (cntInc[ch]),
                .count   (cntVal[ch])
            );
        end
    endgenerate
endmodule
`default_nettype wire

// File: rtl/sop_master.sv
// master end: issues one object read or write at a time over the link
`timescale 1ns/10ps
`default_nettype none
module sop_master (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    sop_od_if.mst            od,
    input  wire logic        cmdValid,
    input  wire logic        cmdWrite,
    input  wire logic [15:0] cmdIndex,
    input  wire logic [7:0]  cmdSub,
    input  wire logic [31:0] cmdData,
    output logic             cmdReady,
    output logic             doneValid,
    output logic [31:0]      doneData,
    output logic             doneAbort
);
    import sop_pkg::*;

    typedef enum logic {SOP_IDLE = 1'b0, SOP_BUSY = 1'b1} sop_mst_e;
    sop_mst_e state;

    // reqValid high for one cycle, request fields held until the next take; a single request in flight
    assign cmdReady = (state == SOP_IDLE);
    wire logic take = cmdValid && cmdReady;

    // master issues each commanded read or write through the link and returns the answer
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state       <= SOP_IDLE;
            od.reqValid <= 1'b0;
            od.reqWrite <= 1'b0;
            od.reqIndex <= '0;
            od.reqSub   <= '0;
            od.reqData  <= '0;
            doneValid   <= 1'b0;
            doneData    <= '0;
            doneAbort   <= 1'b0;
        end else begin
            doneValid <= 1'b0;
            case (state)
                SOP_IDLE: begin
                    if (take) begin
                        state       <= SOP_BUSY;
                        od.reqValid <= 1'b1;
                        od.reqWrite <= cmdWrite;
                        od.reqIndex <= cmdIndex;
                        od.reqSub   <= cmdSub;
                        od.reqData  <= cmdData;
                    end
                end
                SOP_BUSY: begin
                    // device answers one cycle after taking; drop request then
                    od.reqValid <= 1'b0;
                    if (od.rspValid) begin
                        state     <= SOP_IDLE;
                        doneValid <= 1'b1;
                        doneData  <= od.rspData;
                        doneAbort <= od.rspAbort;
                    end
                end
                default: state <= SOP_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// File: rtl/sop_od_if.sv
// object access link between the fieldbus master end and the device end
`timescale 1ns/10ps
`default_nettype none
interface sop_od_if;
    logic        reqValid;
    logic        reqWrite;
    logic [15:0] reqIndex;
    logic [7:0]  reqSub;
    logic [31:0] reqData;
    logic        rspValid;
    logic [31:0] rspData;
    logic        rspAbort;

    modport dev (input reqValid, reqWrite, reqIndex, reqSub, reqData, output rspValid, rspData, rspAbort);
    modport mst (output reqValid, reqWrite, reqIndex, reqSub, reqData, input rspValid, rspData, rspAbort);
endinterface
`default_nettype wire

// File: rtl/sop_pkg.sv
// constants and types shared by both ends of the sync output parameter block
package sop_pkg;
    localparam logic [15:0] IDX_OUT_ASSIGN   = 16'h1c12;
    localparam logic [15:0] IDX_IN_ASSIGN    = 16'h1c13;
    localparam logic [15:0] IDX_OUT_SYNC     = 16'h1c32;
    localparam logic [7:0]  SUB_COUNT        = 8'h00;
    localparam logic [7:0]  SUB_MODE         = 8'h01;
    localparam logic [7:0]  SUB_CYCLE        = 8'h02;
    localparam logic [7:0]  SUB_SHIFT        = 8'h03;
    localparam logic [7:0]  SUB_SUPPORTED    = 8'h04;
    localparam logic [7:0]  SUB_MIN_CYCLE    = 8'h05;
    localparam logic [7:0]  SUB_CALC_COPY    = 8'h06;
    localparam logic [7:0]  SUB_COMMAND      = 8'h08;
    localparam logic [7:0]  SUB_DELAY        = 8'h09;
    localparam logic [7:0]  SUB_MISSED       = 8'h0b;
    localparam logic [7:0]  SUB_OVERRUN      = 8'h0c;
    localparam logic [7:0]  SUB_SHORT        = 8'h0d;
    localparam logic [7:0]  SUB_SYNC_FAIL    = 8'h20;
    localparam logic [7:0]  OUT_SYNC_MAX_SUB = 8'h20;
    localparam logic [15:0] MODES_SUPPORTED  = 16'h8007;
    localparam logic [15:0] OUT_MAP_BASE     = 16'h1600;
    localparam logic [15:0] IN_MAP_BASE      = 16'h1a00;
    localparam logic [15:0] CMD_STOP         = 16'h0000;
    localparam logic [15:0] CMD_START        = 16'h0001;
    localparam logic [31:0] TIME_RESET       = 32'h0000_0000;
    localparam logic [15:0] COUNT_RESET      = 16'h0000;
    localparam int          CLK_PERIOD_NS    = 40;
    localparam logic [31:0] CLK_STEP_NS      = 32'(CLK_PERIOD_NS);
    localparam int          DEF_CHANNELS     = 4;

    typedef enum logic [15:0] {
        SOP_FREE_RUN = 16'h0000,
        SOP_SM_EVENT = 16'h0001,
        SOP_PULSE1   = 16'h0002,
        SOP_PULSE2   = 16'h0003
    } sop_mode_e;
endpackage

// File: rtl/sop_sat_counter.sv
// 16-bit event counter that holds at its top value
`timescale 1ns/10ps
`default_nettype none
module sop_sat_counter #(
    parameter int WIDTH = 16
) (
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic             clear,
    input  wire logic             inc,
    output logic [WIDTH-1:0]      count
);
    import sop_pkg::*;
    wire logic atTop = &count;

    // clear wins over a count in the same cycle: it marks a fresh run state
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            count <= '0;
        end else if (clear) begin
            count <= '0;
        end else if (inc && !atTop) begin
            count <= count + 1'b1;
        end
    end
endmodule
`default_nettype wire
